/* File: mpre_device.sv */
// Device end: serial instruction receiver and multi-panel row erase control
`timescale 1ns/1ps
`default_nettype none
module mpre_device #(
  parameter int PANELS = mpre_pkg::PANEL_COUNT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  mpre_link_if.dev link,
  output logic erase_active_o,
  output logic [PANELS-1:0] erase_panels_o,
  output logic [21:0] erase_addr_o,
  output logic [21:0] table_pointer_o,
  output logic [7:0] mem_control_o,
  output logic [7:0] prog_control_o
);
  import mpre_pkg::*;

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    logic dat_s1;
    logic dat_s2;
    logic [INSTR_BITS-1:0] shreg;
    logic [4:0] bitcnt;
    logic [7:0] wreg;
    logic [21:0] ptr;
    logic [7:0] memctl;
    logic [7:0] progctl;
    logic armed;
    logic erasing;
  } mpre_dev_st_t;

  mpre_dev_st_t st, next_st;
  logic rise, fall;
  logic [INSTR_BITS-1:0] word;

  // ----------------------------------------
  // Link edges from the synchronised clock
  // ----------------------------------------
  assign rise = st.clk_s2 & ~st.clk_d;
  assign fall = ~st.clk_s2 & st.clk_d;
  assign word = {st.dat_s2, st.shreg[INSTR_BITS-1:1]};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.clk_s1 = link.serial_prog_clock;
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_d = st.clk_s2;
    next_st.dat_s1 = link.serial_prog_data;
    next_st.dat_s2 = st.dat_s1;
    // Erase begins on the 4th rising edge of the instruction after a start
    if (rise && st.armed && st.bitcnt == 5'(HOLD_BIT_IDX)) begin
      next_st.armed = 1'b0;
      next_st.erasing = 1'b1;
    end
    // Bits latched on the falling edge, LSB first
    if (fall) begin
      // No internal timer: the erase ends with the clock going low
      next_st.erasing = 1'b0;
      next_st.shreg = word;
      if (st.bitcnt == 5'(INSTR_BITS - 1)) begin
        next_st.bitcnt = 5'd0;
        case (word[CMD_BITS-1:0])
          CMD_CORE: begin
            if (word[19:12] == OP_MOVLW) begin
              next_st.wreg = word[11:4];
            end else if (word[19:12] == OP_MOVWF || word[19:12] == OP_CLRF) begin
              // Pointer or memory control byte write; upper pointer byte holds only six bits
              if (word[11:4] == PTR_UPPER_FILE) begin
                next_st.ptr[21:16] = (word[19:12] == OP_MOVWF) ? st.wreg[5:0] : 6'h00;
              end else if (word[11:4] == PTR_HIGH_FILE) begin
                next_st.ptr[15:8] = (word[19:12] == OP_MOVWF) ? st.wreg : 8'h00;
              end else if (word[11:4] == PTR_LOW_FILE) begin
                next_st.ptr[7:0] = (word[19:12] == OP_MOVWF) ? st.wreg : 8'h00;
              end else if (word[11:4] == MEM_CTRL_FILE) begin
                next_st.memctl = (word[19:12] == OP_MOVWF) ? st.wreg : 8'h00;
              end
            end else if ((word[19:16] == OP_BSF || word[19:16] == OP_BCF) && word[11:4] == MEM_CTRL_FILE) begin
              next_st.memctl[word[15:13]] = (word[19:16] == OP_BSF);
            end
          end
          CMD_TBL_WRITE: begin
            // Only the control register is modelled in configuration space
            if (st.ptr == PROG_CTRL_ADDR && st.memctl[CFG_SEL_BIT]) begin
              next_st.progctl = word[11:4];
            end
          end
          CMD_START_PROG: begin
            // Start counts only in code space with erase and multi-panel set
            next_st.armed = st.memctl[PGM_SEL_BIT] & ~st.memctl[CFG_SEL_BIT]
                            & st.memctl[ROW_ERASE_BIT] & st.memctl[WR_EN_BIT]
                            & st.progctl[MULTI_PANEL_BIT];
          end
          default: begin
            next_st.armed = 1'b0;
          end
        endcase
      end else begin
        next_st.bitcnt = st.bitcnt + 5'd1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.progctl <= PROG_CTRL_RESET;
      st.memctl <= MEM_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs; data pin is never driven by these commands
  // ----------------------------------------
  assign link.dev_data = 1'b0;
  assign link.dev_data_oe = 1'b0;
  assign erase_active_o = st.erasing;
  assign erase_panels_o = {PANELS{st.erasing}};
  assign erase_addr_o = {st.ptr[21:6], 6'h00};
  assign table_pointer_o = st.ptr;
  assign mem_control_o = st.memctl;
  assign prog_control_o = st.progctl;
endmodule
`default_nettype wire

/* File: mpre_link_if.sv */
// Serial programming link between the programmer end and the device end
`timescale 1ns/1ps
`default_nettype none
interface mpre_link_if;
  logic serial_prog_clock;
  logic host_data;
  logic host_data_oe;
  logic dev_data;
  logic dev_data_oe;
  logic serial_prog_data;

  // Resolved data wire, weak high when nobody drives
  assign serial_prog_data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 1'b1);

  modport host (
    output serial_prog_clock,
    output host_data,
    output host_data_oe,
    input serial_prog_data
  );

  modport dev (
    input serial_prog_clock,
    input serial_prog_data,
    output dev_data,
    output dev_data_oe
  );
endinterface
`default_nettype wire

/* File: mpre_pkg.sv */
// Shared constants for the multi-panel row erase link and both of its ends
package mpre_pkg;

  // ----------------------------------------
  // Serial instruction format
  // ----------------------------------------
  localparam int CMD_BITS = 4;
  localparam int OPR_BITS = 16;
  localparam int INSTR_BITS = CMD_BITS + OPR_BITS;
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_TBL_WRITE = 4'hC;
  localparam logic [3:0] CMD_START_PROG = 4'hF;
  localparam int HOLD_BIT_IDX = 3;

  // ----------------------------------------
  // Addresses and values
  // ----------------------------------------
  localparam logic [21:0] PROG_CTRL_ADDR = 22'h3C_0006;
  localparam logic [7:0] PROG_CTRL_RESET = 8'h00;
  localparam logic [7:0] MULTI_PANEL_ENABLE = 8'h40;
  localparam int MULTI_PANEL_BIT = 6;
  localparam int ROW_BYTES = 64;
  localparam logic [21:0] ROW_STEP = 22'h00_0040;
  localparam logic [7:0] MEM_CTRL_RESET = 8'h00;

  // Memory control bit positions
  localparam int PGM_SEL_BIT = 7;
  localparam int CFG_SEL_BIT = 6;
  localparam int ROW_ERASE_BIT = 4;
  localparam int WR_EN_BIT = 3;

  // Pointer byte and memory control file addresses
  localparam logic [7:0] PTR_UPPER_FILE = 8'hF8;
  localparam logic [7:0] PTR_HIGH_FILE = 8'hF7;
  localparam logic [7:0] PTR_LOW_FILE = 8'hF6;
  localparam logic [7:0] MEM_CTRL_FILE = 8'hA6;

  // Core instruction opcodes
  localparam logic [7:0] OP_MOVLW = 8'h0E;
  localparam logic [7:0] OP_MOVWF = 8'h6E;
  localparam logic [7:0] OP_CLRF = 8'h6A;
  localparam logic [3:0] OP_BSF = 4'h8;
  localparam logic [3:0] OP_BCF = 4'h9;
  localparam logic [15:0] OP_NOP = 16'h0000;

  // ----------------------------------------
  // Timing, 200 MHz system clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SER_HALF_NS = 25;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_HOLD_NS = 5000;
  localparam int ERASE_HOLD_CYC = (ERASE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCHARGE_NS = 1000;
  localparam int DISCHARGE_CYC = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_COUNT = 128;
  localparam int PANEL_COUNT = 8;

endpackage

/* File: mpre_programmer.sv */
// Programmer end: drives the multi-panel row erase sequence over the serial link
// Function
// - Device erases one 64-byte row per panel
// - Same row offset in every panel, from pointer
// - Enable via control register at 3C0006h
// - Table write 40h after pointer set 3C0006
// - Select code space, row erase, clear pointer
// - Start command with two dummy bytes
// - Then NOP, clock held high on 4th
// - Erase lasts while serial clock stays high
// - Clock stays low for discharge time after
// - Repeat each row, pointer advanced by 64
// - Pointer offset kept consistent for start
// - Drive on rise, device latches falling, LSB first
// - Twenty bits: 4-bit command, 16-bit operand
// - Command 0000 runs operand as core instruction
// - Pointer is upper, high and low byte
`timescale 1ns/1ps
`default_nettype none
module mpre_programmer #(
  parameter int ROWS = mpre_pkg::ROW_COUNT,
  parameter int HALF_CYC = mpre_pkg::SER_HALF_CYC,
  parameter int HOLD_CYC = mpre_pkg::ERASE_HOLD_CYC,
  parameter int DISCH_CYC = mpre_pkg::DISCHARGE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  mpre_link_if.host link,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] row_o
);
  import mpre_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_HIGH, S_LOW, S_HOLD, S_DISCH} mpre_state_t;

  typedef struct packed {
    mpre_state_t state;
    logic [4:0] step;
    logic [4:0] bitidx;
    logic [31:0] cnt;
    logic [15:0] row;
    logic sclk;
    logic sdat;
    logic doe;
    logic done;
  } mpre_host_st_t;

  localparam logic [4:0] STEP_LOAD = 5'd16;
  localparam logic [4:0] STEP_START = 5'd22;
  localparam logic [4:0] STEP_NOP = 5'd23;

  mpre_host_st_t st, next_st;
  logic [INSTR_BITS-1:0] cur;
  logic [INSTR_BITS-1:0] first_ins;
  logic [INSTR_BITS-1:0] reload_ins;
  logic [INSTR_BITS-1:0] adv_ins;
  logic [4:0] adv_step;
  logic [21:0] row_addr;

  // ----------------------------------------
  // Instruction table, operand above command so bit 0 goes first
  // ----------------------------------------
  function automatic logic [INSTR_BITS-1:0] instr_f(input logic [4:0] step, input logic [21:0] addr);
    logic [3:0] c;
    logic [15:0] o;
    c = CMD_CORE;
    o = OP_NOP;
    case (step)
      5'd0: o = {OP_BSF, 3'(PGM_SEL_BIT), 1'b0, MEM_CTRL_FILE};
      5'd1: o = {OP_BSF, 3'(CFG_SEL_BIT), 1'b0, MEM_CTRL_FILE};
      5'd2: o = {OP_BSF, 3'(WR_EN_BIT), 1'b0, MEM_CTRL_FILE};
      5'd3: o = {OP_MOVLW, 2'b00, PROG_CTRL_ADDR[21:16]};
      5'd4: o = {OP_MOVWF, PTR_UPPER_FILE};
      5'd5: o = {OP_MOVLW, PROG_CTRL_ADDR[15:8]};
      5'd6: o = {OP_MOVWF, PTR_HIGH_FILE};
      5'd7: o = {OP_MOVLW, PROG_CTRL_ADDR[7:0]};
      5'd8: o = {OP_MOVWF, PTR_LOW_FILE};
      5'd9: begin
        c = CMD_TBL_WRITE;
        o = {8'h00, MULTI_PANEL_ENABLE};
      end
      5'd10: o = {OP_BSF, 3'(PGM_SEL_BIT), 1'b0, MEM_CTRL_FILE};
      5'd11: o = {OP_BCF, 3'(CFG_SEL_BIT), 1'b0, MEM_CTRL_FILE};
      5'd12: o = {OP_BSF, 3'(ROW_ERASE_BIT), 1'b0, MEM_CTRL_FILE};
      5'd13: o = {OP_CLRF, PTR_UPPER_FILE};
      5'd14: o = {OP_CLRF, PTR_HIGH_FILE};
      5'd15: o = {OP_CLRF, PTR_LOW_FILE};
      // Pointer reload for rows after the first
      5'd16: o = {OP_MOVLW, 2'b00, addr[21:16]};
      5'd17: o = {OP_MOVWF, PTR_UPPER_FILE};
      5'd18: o = {OP_MOVLW, addr[15:8]};
      5'd19: o = {OP_MOVWF, PTR_HIGH_FILE};
      5'd20: o = {OP_MOVLW, addr[7:0]};
      5'd21: o = {OP_MOVWF, PTR_LOW_FILE};
      5'd22: begin
        c = CMD_START_PROG;
        o = 16'h0000;
      end
      default: o = OP_NOP;
    endcase
    return {o, c};
  endfunction

  // Row base; the offset is only ever moved in whole rows
  assign row_addr = 22'(st.row) * ROW_STEP;
  assign cur = instr_f(st.step, row_addr);
  // Whole next words as nets, so their first bit can be picked out
  assign first_ins = instr_f(5'd0, 22'd0);
  assign reload_ins = instr_f(STEP_LOAD, 22'(st.row + 16'd1) * ROW_STEP);
  assign adv_step = (st.step == 5'd15) ? STEP_START : st.step + 5'd1;
  assign adv_ins = instr_f(adv_step, row_addr);

  // ----------------------------------------
  // Sequencer: one bit per high and low half period
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.state)
      S_IDLE: begin
        next_st.sclk = 1'b0;
        next_st.doe = 1'b0;
        if (start_i) begin
          next_st.state = S_HIGH;
          next_st.step = 5'd0;
          next_st.bitidx = 5'd0;
          next_st.row = 16'd0;
          next_st.cnt = 32'd0;
          next_st.doe = 1'b1;
          next_st.sclk = 1'b1;
          next_st.sdat = first_ins[0];
        end
      end
      S_HIGH: begin
        if (st.cnt == 32'(HALF_CYC - 1)) begin
          next_st.cnt = 32'd0;
          // Fourth clock of the trailing NOP stays high for the erase
          if (st.step == STEP_NOP && st.bitidx == 5'(HOLD_BIT_IDX)) begin
            next_st.state = S_HOLD;
          end else begin
            next_st.state = S_LOW;
            next_st.sclk = 1'b0;
          end
        end else begin
          next_st.cnt = st.cnt + 32'd1;
        end
      end
      S_HOLD: begin
        // Erase length is set here alone, the device has no timer
        if (st.cnt == 32'(HOLD_CYC - 1)) begin
          next_st.cnt = 32'd0;
          next_st.state = S_DISCH;
          next_st.sclk = 1'b0;
        end else begin
          next_st.cnt = st.cnt + 32'd1;
        end
      end
      S_DISCH: begin
        // Clock kept low so the array's high voltage can bleed off
        if (st.cnt == 32'(DISCH_CYC - 1)) begin
          next_st.cnt = 32'd0;
          next_st.state = S_LOW;
        end else begin
          next_st.cnt = st.cnt + 32'd1;
        end
      end
      S_LOW: begin
        if (st.cnt == 32'(HALF_CYC - 1)) begin
          next_st.cnt = 32'd0;
          next_st.state = S_HIGH;
          next_st.sclk = 1'b1;
          if (st.bitidx == 5'(INSTR_BITS - 1)) begin
            next_st.bitidx = 5'd0;
            if (st.step == STEP_NOP) begin
              if (st.row == 16'(ROWS - 1)) begin
                next_st.state = S_IDLE;
                next_st.sclk = 1'b0;
                next_st.doe = 1'b0;
                next_st.done = 1'b1;
              end else begin
                next_st.row = st.row + 16'd1;
                next_st.step = STEP_LOAD;
                next_st.sdat = reload_ins[0];
              end
            end else begin
              // First row uses the cleared pointer, no reload needed
              next_st.step = adv_step;
              next_st.sdat = adv_ins[0];
            end
          end else begin
            // Next bit presented with the rising edge
            next_st.bitidx = st.bitidx + 5'd1;
            next_st.sdat = cur[st.bitidx + 5'd1];
          end
        end else begin
          next_st.cnt = st.cnt + 32'd1;
        end
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.state <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.serial_prog_clock = st.sclk;
  assign link.host_data = st.sdat;
  assign link.host_data_oe = st.doe;
  assign busy_o = (st.state != S_IDLE);
  assign done_o = st.done;
  assign row_o = st.row;
endmodule
`default_nettype wire

/* File: mpre_props.sv */
// Concurrent checks on the serial link and the erase outputs of the device end
`timescale 1ns/1ps
`default_nettype none
module mpre_props #(
  parameter int PANELS = 8,
  parameter int HALF_CYC = 5,
  parameter int HOLD_CYC = 1000,
  parameter int DISCH_CYC = 200
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic serial_prog_clock,
  input wire logic host_data,
  input wire logic host_data_oe,
  input wire logic erase_active_o,
  input wire logic [PANELS-1:0] erase_panels_o,
  input wire logic [21:0] erase_addr_o,
  input wire logic [21:0] table_pointer_o,
  input wire logic [7:0] mem_control_o,
  input wire logic [7:0] prog_control_o
);
  import mpre_pkg::*;
  int hi_cnt;
  int lo_cnt;

  // ----------------------------------------
  // Link clock run lengths
  // ----------------------------------------
  // Low count saturates, so a long idle gap never wraps
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hi_cnt <= 0;
      lo_cnt <= DISCH_CYC;
    end else if (serial_prog_clock) begin
      hi_cnt <= hi_cnt + 1;
      lo_cnt <= 0;
    end else begin
      hi_cnt <= 0;
      lo_cnt <= (lo_cnt < DISCH_CYC) ? lo_cnt + 1 : lo_cnt;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Pin drops and stays low long enough for the erase to wind down
  sequence s_pin_drop;
    $fell(serial_prog_clock) ##1 !serial_prog_clock [*3];
  endsequence

  // Wire timing: half periods, long hold and discharge gap
  chk_discharge_gap: assert property ($rose(serial_prog_clock) |->
    (lo_cnt == HALF_CYC || lo_cnt >= DISCH_CYC)) else $error("clock low time wrong before a rise");
  chk_hold_length: assert property ($fell(serial_prog_clock) |->
    (hi_cnt == HALF_CYC || hi_cnt >= HOLD_CYC)) else $error("clock high time wrong before a fall");
  // Data may not move while the clock is high, or the fall latches garbage
  chk_data_stable_high: assert property (serial_prog_clock && $past(serial_prog_clock) |->
    $stable(host_data)) else $error("data changed while clock high");
  chk_drive_in_frame: assert property (serial_prog_clock |-> host_data_oe)
    else $error("data not driven while clocking");
  // Erase only while the pin clock is held, with the sync delay allowed
  chk_erase_tracks_clk: assert property (erase_active_o |->
    ($past(serial_prog_clock, 2) || $past(serial_prog_clock, 3) || $past(serial_prog_clock, 4)))
    else $error("erase active without a held clock");
  chk_erase_ends: assert property ((erase_active_o ##0 s_pin_drop) |-> ##[0:2] !erase_active_o)
    else $error("erase outlived the clock");
  chk_all_panels: assert property (erase_active_o |-> erase_panels_o == {PANELS{1'b1}})
    else $error("not every panel erasing");
  chk_row_offset: assert property (erase_active_o |->
    erase_addr_o == {table_pointer_o[21:6], 6'h00}) else $error("erase offset differs from pointer");
  chk_enable_write: assert property ($changed(prog_control_o) |->
    (prog_control_o == MULTI_PANEL_ENABLE && table_pointer_o == PROG_CTRL_ADDR))
    else $error("programming control written wrongly");
  chk_erase_gated: assert property ($rose(erase_active_o) |->
    (prog_control_o[MULTI_PANEL_BIT] && mem_control_o[PGM_SEL_BIT] && !mem_control_o[CFG_SEL_BIT]
    && mem_control_o[ROW_ERASE_BIT] && mem_control_o[WR_EN_BIT])) else $error("erase started unarmed");
endmodule
`default_nettype wire

/* File: multi_panel_row_erase_tb.sv */
// Testbench: programmer end drives the device end through the link
`timescale 1ns/1ps
`default_nettype none
module multi_panel_row_erase_tb;
  import mpre_pkg::*;
  localparam int ROWS = 3;
  localparam int HALF = 2;
  localparam int HOLD = 20;
  localparam int DISCH = 10;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic busy_o, done_o, erase_active_o;
  logic [15:0] row_o;
  logic [PANEL_COUNT-1:0] erase_panels_o;
  logic [21:0] erase_addr_o, table_pointer_o;
  logic [7:0] mem_control_o, prog_control_o;
  int num_errors = 0;
  int check_count = 0;
  integer seed = 32'h0000_dfe2;
  logic [19:0] exp_ins[$];
  logic [21:0] exp_addr[$];
  logic [19:0] shreg;
  logic prev_clk;
  int nbits, hi_len, hold_len, er_len;

  mpre_link_if link();
  mpre_device #(.PANELS(PANEL_COUNT)) i_mpre_device(.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
    .erase_active_o(erase_active_o), .erase_panels_o(erase_panels_o), .erase_addr_o(erase_addr_o),
    .table_pointer_o(table_pointer_o), .mem_control_o(mem_control_o), .prog_control_o(prog_control_o));
  mpre_programmer #(.ROWS(ROWS), .HALF_CYC(HALF), .HOLD_CYC(HOLD), .DISCH_CYC(DISCH)) i_mpre_programmer(
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .link(link), .busy_o(busy_o),
    .done_o(done_o), .row_o(row_o));
  mpre_props #(.PANELS(PANEL_COUNT), .HALF_CYC(HALF), .HOLD_CYC(HOLD), .DISCH_CYC(DISCH)) i_mpre_props(
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_prog_clock(link.serial_prog_clock),
    .host_data(link.host_data), .host_data_oe(link.host_data_oe), .erase_active_o(erase_active_o),
    .erase_panels_o(erase_panels_o), .erase_addr_o(erase_addr_o), .table_pointer_o(table_pointer_o),
    .mem_control_o(mem_control_o), .prog_control_o(prog_control_o));

  // 200 MHz system clock
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Inputs always move one nanosecond after the edge
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask

  function automatic logic [19:0] ins(input logic [3:0] c, input logic [15:0] o);
    return {o, c};
  endfunction

  function automatic logic [15:0] bitop(input logic [3:0] op, input int b);
    return {op, 3'(b), 1'b0, MEM_CTRL_FILE};
  endfunction

  task automatic load_ptr(input logic [21:0] a);
    exp_ins.push_back(ins(CMD_CORE, {OP_MOVLW, 2'b00, a[21:16]}));
    exp_ins.push_back(ins(CMD_CORE, {OP_MOVWF, PTR_UPPER_FILE}));
    exp_ins.push_back(ins(CMD_CORE, {OP_MOVLW, a[15:8]}));
    exp_ins.push_back(ins(CMD_CORE, {OP_MOVWF, PTR_HIGH_FILE}));
    exp_ins.push_back(ins(CMD_CORE, {OP_MOVLW, a[7:0]}));
    exp_ins.push_back(ins(CMD_CORE, {OP_MOVWF, PTR_LOW_FILE}));
  endtask

  // Notes the whole expected stream, then starts and waits for done
  task automatic run_all();
    int n;
    exp_ins.push_back(ins(CMD_CORE, bitop(OP_BSF, PGM_SEL_BIT)));
    exp_ins.push_back(ins(CMD_CORE, bitop(OP_BSF, CFG_SEL_BIT)));
    exp_ins.push_back(ins(CMD_CORE, bitop(OP_BSF, WR_EN_BIT)));
    load_ptr(PROG_CTRL_ADDR);
    exp_ins.push_back(ins(CMD_TBL_WRITE, {8'h00, MULTI_PANEL_ENABLE}));
    exp_ins.push_back(ins(CMD_CORE, bitop(OP_BSF, PGM_SEL_BIT)));
    exp_ins.push_back(ins(CMD_CORE, bitop(OP_BCF, CFG_SEL_BIT)));
    exp_ins.push_back(ins(CMD_CORE, bitop(OP_BSF, ROW_ERASE_BIT)));
    exp_ins.push_back(ins(CMD_CORE, {OP_CLRF, PTR_UPPER_FILE}));
    exp_ins.push_back(ins(CMD_CORE, {OP_CLRF, PTR_HIGH_FILE}));
    exp_ins.push_back(ins(CMD_CORE, {OP_CLRF, PTR_LOW_FILE}));
    for (int r = 0; r < ROWS; r++) begin
      if (r > 0)
        load_ptr(22'(r) * ROW_STEP);
      exp_ins.push_back(ins(CMD_START_PROG, 16'h0000));
      exp_ins.push_back(ins(CMD_CORE, OP_NOP));
      exp_addr.push_back(22'(r) * ROW_STEP);
    end
    start_i = 1'b1;
    step();
    start_i = 1'b0;
    n = 0;
    // Random starts while busy must be ignored; none near the end
    while (n < 20000) begin
      step();
      // Busy drops in the very cycle that done pulses
      if (done_o === 1'b1)
        break;
      chk("busy", busy_o, 1'b1);
      start_i = (row_o < 16'(ROWS - 1)) ? 1'($random(seed)) : 1'b0;
      n++;
    end
    start_i = 1'b0;
    if (n >= 20000) begin
      num_errors++;
      return;
    end
    chk("busy at done", busy_o, 1'b0);
    chk("last row", row_o, 32'(ROWS - 1));
    chk("prog control", prog_control_o, MULTI_PANEL_ENABLE);
    chk("mem control", mem_control_o, 8'h98);
    repeat (DISCH + HALF) step();
    chk("idle", busy_o, 1'b0);
  endtask

  // ----------------------------------------
  // Monitor: decodes the wire and the erase window
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      nbits = 0;
      hi_len = 0;
      er_len = 0;
      prev_clk = 1'b0;
    end else begin
      if (link.serial_prog_clock === 1'b1) begin
        hi_len++;
      end else if (prev_clk === 1'b1) begin
        shreg = {link.serial_prog_data, shreg[19:1]};
        nbits++;
        if (hi_len > HALF)
          hold_len = hi_len;
        hi_len = 0;
        if (nbits == INSTR_BITS) begin
          nbits = 0;
          chk("instruction", shreg, exp_ins.size() > 0 ? exp_ins.pop_front() : 20'bx);
        end
      end
      prev_clk = link.serial_prog_clock;
      if (erase_active_o === 1'b1) begin
        if (er_len == 0) begin
          chk("erase addr", erase_addr_o, exp_addr.size() > 0 ? exp_addr.pop_front() : 22'bx);
          chk("panels", erase_panels_o, {PANEL_COUNT{1'b1}});
        end
        er_len++;
      end else if (er_len > 0) begin
        chk("erase length", er_len, hold_len);
        er_len = 0;
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    chk("prog reset", prog_control_o, PROG_CTRL_RESET);
    chk("mem reset", mem_control_o, MEM_CTRL_RESET);
    chk("erase reset", erase_active_o, 1'b0);
    run_all();
    run_all();
    chk("pending", exp_ins.size() + exp_addr.size(), 0);
    test_done();
  end
endmodule
`default_nettype wire
